// ===== test/adsc_afe_model.sv
`timescale 1ns/1ns
module adsc_afe_model (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// converter side
	input wire logic sample_hold_i,
	input wire logic [9:0] tap_code_i,
	// level of the selected input
	input wire logic [9:0] level_i,
	// comparator decision
	output logic comparator_o
);
	logic [9:0] held_reg;
	logic wobble_reg;

	// ****************************************
	// sample and hold
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			held_reg <= 10'h000;
			wobble_reg <= 1'b0;
		end else begin
			wobble_reg <= ~wobble_reg;
			if (sample_hold_i) begin
				held_reg <= level_i;
			end
		end
	end

	// no tap means no decision: a changing level so a stale bit is never trusted
	always_comb begin
		if (tap_code_i != 10'h000) begin
			comparator_o = (held_reg >= tap_code_i);
		end else begin
			comparator_o = wobble_reg;
		end
	end
endmodule : adsc_afe_model

// ===== test/adsc_ctrl_tb.sv
`timescale 1ns/1ns
module adsc_ctrl_tb;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i = 1'b1;
	logic [15:0] cpu_addr_i = 16'h0000;
	logic cpu_wr_i = 1'b0;
	logic cpu_bit_wr_i = 1'b0;
	logic [2:0] cpu_bit_sel_i = 3'h0;
	logic [7:0] cpu_wdata_i = 8'h00;
	logic ext_trigger_i = 1'b0;
	logic [5:0] ext_irq_pin_i = 6'h00;
	logic comparator_i;
	logic [7:0] cpu_rdata_o;
	logic booster_enable_o;
	logic sample_hold_o;
	logic [9:0] tap_code_o;
	logic [3:0] channel_code_o;
	logic [15:0] conversion_result_o;
	logic conversion_end_irq_o;
	logic [5:0] ext_irq_edge_o;
	logic [9:0] level;
	int mismatches = 0;
	int cmp_count = 0;
	int irq_n;
	logic irq_got;
	int steps [3] = '{48, 40, 32};
	logic [2:0] codes [3] = '{3'h4, 3'h5, 3'h6};

	always #20 clk_sys_i = ~clk_sys_i;

	function automatic logic [9:0] lvl(input logic [3:0] ch);
		if (ch == 4'h0) return 10'h3ff;
		if (ch == 4'h9) return 10'h000;
		return 10'h2a5 + 10'(ch) * 10'h047;
	endfunction : lvl

	assign level = lvl(channel_code_o);

	adsc_ctrl adsc_ctrl_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
		.cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_bit_wr_i(cpu_bit_wr_i),
		.cpu_bit_sel_i(cpu_bit_sel_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
		.ext_trigger_i(ext_trigger_i), .comparator_i(comparator_i),
		.ext_irq_pin_i(ext_irq_pin_i), .booster_enable_o(booster_enable_o),
		.sample_hold_o(sample_hold_o), .tap_code_o(tap_code_o),
		.channel_code_o(channel_code_o), .conversion_result_o(conversion_result_o),
		.conversion_end_irq_o(conversion_end_irq_o), .ext_irq_edge_o(ext_irq_edge_o));

	adsc_afe_model adsc_afe_model_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.sample_hold_i(sample_hold_o), .tap_code_i(tap_code_o), .level_i(level),
		.comparator_o(comparator_i));

	// ****************************************
	// access and check tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		cpu_addr_i <= a;
		cpu_wdata_i <= d;
		cpu_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		cpu_wr_i <= 1'b0;
	endtask : wr

	task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
		@(posedge clk_sys_i);
		cpu_addr_i <= a;
		cpu_bit_sel_i <= b;
		cpu_wdata_i <= {7'h00, v};
		cpu_bit_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		cpu_bit_wr_i <= 1'b0;
	endtask : bwr

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		cpu_addr_i <= a;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("read data", {8'h00, exp}, {8'h00, cpu_rdata_o});
	endtask : rd

	// counts whole cycles before the end pulse, gives up after lim
	task automatic wait_irq(input int lim);
		irq_n = 0;
		irq_got = 1'b0;
		while (irq_n < lim && !irq_got) begin
			@(posedge clk_sys_i);
			#1;
			if (conversion_end_irq_o === 1'b1) irq_got = 1'b1;
			else irq_n++;
		end
	endtask : wait_irq

	task automatic conv_chk(input int lim, input logic [3:0] ch);
		wait_irq(lim);
		chk("end pulse", 16'h0001, {15'h0000, irq_got});
		chk("result", {lvl(ch), 6'h00}, conversion_result_o);
	endtask : conv_chk

	task automatic pin_chk(input logic [5:0] pins, input logic [5:0] exp);
		logic [5:0] seen;
		seen = 6'h00;
		@(posedge clk_sys_i);
		ext_irq_pin_i <= pins;
		repeat (10) begin
			@(posedge clk_sys_i);
			#1;
			seen = seen | ext_irq_edge_o;
		end
		chk("pin edges", {10'h000, exp}, {10'h000, seen});
	endtask : pin_chk

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(adsc_pkg::ADDR_RISE_EN, 8'h00);
		rd(adsc_pkg::ADDR_FALL_EN, 8'h00);
		rd(adsc_pkg::ADDR_MODE, 8'h00);
		rd(adsc_pkg::ADDR_CHAN, 8'h00);
		rd(16'hff82, 8'h00);
		$display("test reset values done");
		wr(adsc_pkg::ADDR_CHAN, 8'hff);
		rd(adsc_pkg::ADDR_CHAN, 8'h0f);
		chk("channel code", 16'h000f, {12'h000, channel_code_o});
		bwr(adsc_pkg::ADDR_CHAN, 3'h3, 1'b0);
		rd(adsc_pkg::ADDR_CHAN, 8'h0f);
		bwr(adsc_pkg::ADDR_MODE, 3'h0, 1'b1);
		rd(adsc_pkg::ADDR_MODE, 8'h01);
		chk("booster", 16'h0001, {15'h0000, booster_enable_o});
		wr(adsc_pkg::ADDR_RISE_EN, 8'hff);
		rd(adsc_pkg::ADDR_RISE_EN, 8'h3f);
		bwr(adsc_pkg::ADDR_FALL_EN, 3'h4, 1'b1);
		rd(adsc_pkg::ADDR_FALL_EN, 8'h10);
		// a write while the clock enable is low must not land
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		wr(adsc_pkg::ADDR_RISE_EN, 8'h00);
		ce_i <= 1'b1;
		rd(adsc_pkg::ADDR_RISE_EN, 8'h3f);
		$display("test register access done");
		wr(adsc_pkg::ADDR_RISE_EN, 8'h05);
		wr(adsc_pkg::ADDR_FALL_EN, 8'h06);
		pin_chk(6'h3f, 6'h05);
		pin_chk(6'h00, 6'h06);
		$display("test pin edges done");
		// booster settles 14 us before run
		repeat (350) @(posedge clk_sys_i);
		wr(adsc_pkg::ADDR_CHAN, 8'h00);
		// 384 clocks is the shortest code that meets 14 us at this clock
		wr(adsc_pkg::ADDR_MODE, 8'hb1);
		conv_chk(12 * 32 + 12, 4'h0);
		wr(adsc_pkg::ADDR_CHAN, 8'h09);
		conv_chk(12 * 32 + 12, 4'h9);
		wait_irq(12 * 32 + 12);
		chk("repeat", 16'h0001, {15'h0000, irq_got});
		$display("test software start done");
		for (int i = 0; i < 3; i++) begin
			wr(adsc_pkg::ADDR_MODE, 8'h01);
			wr(adsc_pkg::ADDR_MODE, {2'b10, codes[i], 3'b001});
			wait_irq(12 * steps[i] + 12);
			wait_irq(12 * steps[i] + 12);
			chk("period", 16'h0001, {15'h0000, irq_got && irq_n + 1 >= 12 * steps[i]
				&& irq_n + 1 <= 12 * steps[i] + 6});
		end
		$display("test conversion times done");
		wr(adsc_pkg::ADDR_CHAN, 8'h03);
		for (int e = 0; e < 4; e++) begin
			wr(adsc_pkg::ADDR_MODE, 8'h01);
			wr(adsc_pkg::ADDR_MODE, 8'hf1 | 8'(e << 1));
			repeat (20) @(posedge clk_sys_i);
			ext_trigger_i <= 1'b1;
			wait_irq(500);
			chk("rise start", 16'(e >> 1), {15'h0000, irq_got});
			@(posedge clk_sys_i);
			ext_trigger_i <= 1'b0;
			wait_irq(500);
			chk("fall start", 16'(e & 1), {15'h0000, irq_got});
			if (e == 3) chk("result", {lvl(4'h3), 6'h00}, conversion_result_o);
			wait_irq(800);
			chk("no retrigger", 16'h0000, {15'h0000, irq_got});
		end
		$display("test hardware start done");
		wr(adsc_pkg::ADDR_MODE, 8'h01);
		wr(adsc_pkg::ADDR_MODE, 8'hb1);
		repeat (100) @(posedge clk_sys_i);
		wr(adsc_pkg::ADDR_CHAN, 8'h05);
		conv_chk(12 * 32 + 12, 4'h5);
		chk("restart length", 16'h0001, {15'h0000, irq_n >= 12 * 32 - 2});
		repeat (100) @(posedge clk_sys_i);
		wr(adsc_pkg::ADDR_MODE, 8'h01);
		wait_irq(800);
		chk("stopped", 16'h0000, {15'h0000, irq_got});
		wr(adsc_pkg::ADDR_MODE, 8'h00);
		rd(adsc_pkg::ADDR_MODE, 8'h00);
		chk("booster off", 16'h0000, {15'h0000, booster_enable_o});
		$display("test abort and stop done");
		wrap_up();
	end

	initial begin
		repeat (40000) @(posedge clk_sys_i);
		mismatches++;
		wrap_up();
	end
endmodule : adsc_ctrl_tb

// ===== verilog/adsc_ctrl.sv
`timescale 1ns/1ns
// Function
// R1: mode bit 7 stops or enables conversion.
// R2: mode bit 6 picks software start or external trigger start.
// R3: time field picks 144, 576, 480 or 384 clocks; others prohibited.
// R4: mode bits 2:1 pick trigger edge none, falling, rising or both.
// R5: mode bit 0 drives the booster; set it before run.
// R6: software waits 14 us from booster on to run on.
// R7: software clears run before clearing booster.
// R8: software stops conversion before changing the time field.
// R9: software picks a time code giving at least 14 us.
// R10: channel bits 3:0 pick input 0 to 9; bits 7:4 read zero.
// R11: channel register takes byte writes only; others take bit writes too.
// R12: per pin 0-5 rising and falling enables pick the valid edge.
// R13: sample the channel for a fixed interval, then hold.
// R14: start with bit 9 set against the half tap.
// R15: each lower bit is trial-set and kept if input at least tap.
// R16: after ten bits the value moves to the result register.
// R17: end interrupt raised together with the result latch.
// R18: hardware start converts once per valid edge, then waits.
// R19: software start repeats conversions until run is cleared.
// R20: mode or channel write aborts; restart if run stays set.
// R21: writing mode with run clear stops conversion at once.
// R22: ten steps spread over the count, comparator sampled per step; code spreads 12 steps (2 sample, then 10 compare).
module adsc_ctrl (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// cpu register port
	input wire logic [15:0] cpu_addr_i,
	input wire logic cpu_wr_i,
	input wire logic cpu_bit_wr_i,
	input wire logic [2:0] cpu_bit_sel_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic [7:0] cpu_rdata_o,
	// pins
	input wire logic ext_trigger_i,
	input wire logic comparator_i,
	input wire logic [5:0] ext_irq_pin_i,
	// analog front end
	output logic booster_enable_o,
	output logic sample_hold_o,
	output logic [9:0] tap_code_o,
	output logic [3:0] channel_code_o,
	// results and events
	output logic [15:0] conversion_result_o,
	output logic conversion_end_irq_o,
	output logic [5:0] ext_irq_edge_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_CONVERT} adsc_state_e;

	adsc_seq_if sq ();

	adsc_sar_seq u_seq (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.sq(sq.seq)
	);

	// ****************************************
	// register file
	// ****************************************
	logic [7:0] converter_mode_reg, converter_mode_next;
	logic [7:0] channel_select_reg, channel_select_next;
	logic [7:0] rising_edge_enable_reg, rising_edge_enable_next;
	logic [7:0] falling_edge_enable_reg, falling_edge_enable_next;
	logic [7:0] rdata_reg, rdata_next;
	logic any_wr;
	logic mode_wr;
	logic chan_wr;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic byte_wr,
		input logic bit_wr, input logic [2:0] sel, input logic [7:0] wd);
		logic [7:0] m;
		m = 8'h01 << sel;
		if (byte_wr) begin
			merge = wd;
		end else if (bit_wr) begin
			merge = (old & ~m) | (wd[0] ? m : 8'h00);
		end else begin
			merge = old;
		end
	endfunction : merge

	assign any_wr = cpu_wr_i || cpu_bit_wr_i;
	assign mode_wr = any_wr && cpu_addr_i == adsc_pkg::ADDR_MODE;
	// bit writes do not reach the channel register
	assign chan_wr = cpu_wr_i && cpu_addr_i == adsc_pkg::ADDR_CHAN; // R11

	always_comb begin
		converter_mode_next = converter_mode_reg;
		rising_edge_enable_next = rising_edge_enable_reg;
		falling_edge_enable_next = falling_edge_enable_reg;
		channel_select_next = channel_select_reg;
		if (mode_wr) begin
			converter_mode_next = merge(converter_mode_reg, cpu_wr_i, cpu_bit_wr_i,
				cpu_bit_sel_i, cpu_wdata_i); // R11
		end
		if (chan_wr) begin
			channel_select_next = cpu_wdata_i & adsc_pkg::CHAN_MASK; // R10
		end
		if (any_wr && cpu_addr_i == adsc_pkg::ADDR_RISE_EN) begin
			rising_edge_enable_next = adsc_pkg::EDGE_MASK & merge(rising_edge_enable_reg,
				cpu_wr_i, cpu_bit_wr_i, cpu_bit_sel_i, cpu_wdata_i); // R11
		end
		if (any_wr && cpu_addr_i == adsc_pkg::ADDR_FALL_EN) begin
			falling_edge_enable_next = adsc_pkg::EDGE_MASK & merge(falling_edge_enable_reg,
				cpu_wr_i, cpu_bit_wr_i, cpu_bit_sel_i, cpu_wdata_i); // R11
		end
		unique case (cpu_addr_i)
			adsc_pkg::ADDR_MODE: rdata_next = converter_mode_reg;
			adsc_pkg::ADDR_CHAN: rdata_next = channel_select_reg;
			adsc_pkg::ADDR_RISE_EN: rdata_next = rising_edge_enable_reg;
			adsc_pkg::ADDR_FALL_EN: rdata_next = falling_edge_enable_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			converter_mode_reg <= adsc_pkg::MODE_RESET;
			channel_select_reg <= adsc_pkg::CHAN_RESET;
			rising_edge_enable_reg <= adsc_pkg::EDGE_RESET;
			falling_edge_enable_reg <= adsc_pkg::EDGE_RESET;
			rdata_reg <= 8'h00;
		end else if (ce_i) begin
			converter_mode_reg <= converter_mode_next;
			channel_select_reg <= channel_select_next;
			rising_edge_enable_reg <= rising_edge_enable_next;
			falling_edge_enable_reg <= falling_edge_enable_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	// bit 7 comparator, bit 6 trigger, bits 5:0 interrupt pins
	logic [7:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
	logic [7:0] pins;
	logic [7:0] agree;
	logic [5:0] edge_next, edge_reg;
	logic trig_rise;
	logic trig_fall;
	logic trig_valid;

	assign pins = {comparator_i, ext_trigger_i, ext_irq_pin_i};
	// a change counts only once stages two and three agree
	assign agree = ~(s2_reg ^ s3_reg);
	assign lvl_next = (agree & s2_reg) | (~agree & lvl_reg);
	assign trig_rise = lvl_next[6] && !lvl_reg[6];
	assign trig_fall = !lvl_next[6] && lvl_reg[6];
	assign trig_valid = (converter_mode_reg[adsc_pkg::MODE_EDGE_LSB + 1] && trig_rise)
		|| (converter_mode_reg[adsc_pkg::MODE_EDGE_LSB] && trig_fall); // R4

	genvar gi;
	generate
		for (gi = 0; gi < adsc_pkg::EXT_PINS; gi++) begin : g_pin_edge
			assign edge_next[gi] = (rising_edge_enable_reg[gi] && lvl_next[gi] && !lvl_reg[gi])
				|| (falling_edge_enable_reg[gi] && !lvl_next[gi] && lvl_reg[gi]); // R12
		end
	endgenerate

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			s1_reg <= 8'h00;
			s2_reg <= 8'h00;
			s3_reg <= 8'h00;
			lvl_reg <= 8'h00;
			edge_reg <= 6'h00;
		end else if (ce_i) begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
			edge_reg <= edge_next;
		end
	end

	// ****************************************
	// conversion control
	// ****************************************
	adsc_state_e state_reg, state_next;
	logic [15:0] result_reg, result_next;
	logic irq_reg, irq_next;
	logic run;
	logic hw_start;
	logic [5:0] step_len;
	logic start;
	logic abort;

	assign run = converter_mode_reg[adsc_pkg::MODE_RUN_BIT];
	assign hw_start = converter_mode_reg[adsc_pkg::MODE_HW_BIT];

	always_comb begin
		unique case (converter_mode_reg[adsc_pkg::MODE_TIME_LSB +: 3])
			adsc_pkg::TIME_576: step_len = 6'(adsc_pkg::CONV_CYC_576 / adsc_pkg::SEQ_STEPS);
			adsc_pkg::TIME_480: step_len = 6'(adsc_pkg::CONV_CYC_480 / adsc_pkg::SEQ_STEPS);
			adsc_pkg::TIME_384: step_len = 6'(adsc_pkg::CONV_CYC_384 / adsc_pkg::SEQ_STEPS);
			// prohibited codes fall back to the shortest legal time
			default: step_len = 6'(adsc_pkg::CONV_CYC_144 / adsc_pkg::SEQ_STEPS); // R3
		endcase
	end

	always_comb begin
		state_next = state_reg;
		start = 1'b0;
		abort = 1'b0;
		result_next = result_reg;
		irq_next = 1'b0;
		if (mode_wr || chan_wr) begin
			abort = 1'b1; // R20 R21
			if (!converter_mode_next[adsc_pkg::MODE_RUN_BIT]) begin
				state_next = ST_IDLE; // R1 R21
			end else if (converter_mode_next[adsc_pkg::MODE_HW_BIT]) begin
				state_next = ST_WAIT_TRIG; // R2 R20
			end else begin
				state_next = ST_CONVERT; // R20
			end
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					state_next = ST_IDLE;
				end
				ST_WAIT_TRIG: begin
					if (trig_valid) begin
						state_next = ST_CONVERT; // R18
					end
				end
				ST_CONVERT: begin
					if (!sq.busy && !sq.done) begin
						start = 1'b1;
					end
					if (sq.done) begin
						result_next = {sq.result, adsc_pkg::RES_PAD'(0)}; // R16
						irq_next = 1'b1; // R17
						state_next = hw_start ? ST_WAIT_TRIG : ST_CONVERT; // R18 R19
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			result_reg <= 16'h0000;
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			result_reg <= result_next;
			irq_reg <= irq_next;
		end
	end

	assign sq.start = start && run;
	assign sq.abort = abort;
	assign sq.step_len = step_len;
	assign sq.cmp = lvl_reg[7];

	assign cpu_rdata_o = rdata_reg;
	assign booster_enable_o = converter_mode_reg[adsc_pkg::MODE_BOOST_BIT]; // R5
	assign sample_hold_o = sq.sampling; // R13
	assign tap_code_o = sq.trial; // R15
	assign channel_code_o = channel_select_reg[3:0]; // R10
	assign conversion_result_o = result_reg;
	assign conversion_end_irq_o = irq_reg;
	assign ext_irq_edge_o = edge_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	run_stop_a: assert property (ce_i && mode_wr && cpu_wr_i && !cpu_wdata_i[7] // R21
		|=> !sq.busy && state_reg == ST_IDLE)
		else $error("run clear did not stop conversion");
	booster_bit_a: assert property (ce_i && mode_wr && cpu_wr_i // R5
		|=> booster_enable_o == $past(cpu_wdata_i[adsc_pkg::MODE_BOOST_BIT]))
		else $error("booster output does not follow written mode bit 0");
	chan_zero_a: assert property (channel_select_reg[7:4] == 4'h0) // R10
		else $error("channel upper bits not zero");
	chan_byte_a: assert property (cpu_bit_wr_i && !cpu_wr_i // R11
		&& cpu_addr_i == adsc_pkg::ADDR_CHAN |=> $stable(channel_select_reg))
		else $error("bit write changed channel register");
	hw_wait_a: assert property (ce_i && state_reg == ST_CONVERT && hw_start // R18
		&& sq.done && !any_wr |=> state_reg == ST_WAIT_TRIG)
		else $error("hardware start did not wait for trigger");
	sw_repeat_a: assert property (ce_i && state_reg == ST_CONVERT && !hw_start // R19
		&& sq.done && !any_wr ##1 ce_i |=> sq.busy)
		else $error("software start did not repeat");
	result_irq_a: assert property (ce_i && sq.done && !abort // R16 R17
		&& state_reg == ST_CONVERT
		|=> conversion_end_irq_o && conversion_result_o[15:6] == $past(sq.result))
		else $error("result and end interrupt not together");
	no_edge_a: assert property (state_reg == ST_WAIT_TRIG // R4
		&& converter_mode_reg[2:1] == 2'b00 && !any_wr && ce_i
		|=> state_reg == ST_WAIT_TRIG)
		else $error("trigger taken with no edge selected");
	pin_edge_a: assert property (ext_irq_edge_o[0] |-> // R12
		$past(rising_edge_enable_reg[0] || falling_edge_enable_reg[0]))
		else $error("pin edge reported while disabled");
	write_abort_a: assert property (ce_i && chan_wr |=> !sq.busy) // R20
		else $error("channel write did not abort");
endmodule : adsc_ctrl

// ===== verilog/adsc_pkg.sv
package adsc_pkg;
	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [15:0] ADDR_RISE_EN = 16'hff48;
	localparam logic [15:0] ADDR_FALL_EN = 16'hff49;
	localparam logic [15:0] ADDR_MODE = 16'hff80;
	localparam logic [15:0] ADDR_CHAN = 16'hff81;

	// ****************************************
	// reset values and write masks
	// ****************************************
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CHAN_RESET = 8'h00;
	localparam logic [7:0] EDGE_RESET = 8'h00;
	localparam logic [7:0] CHAN_MASK = 8'h0f;
	localparam logic [7:0] EDGE_MASK = 8'h3f;

	// ****************************************
	// mode register fields
	// ****************************************
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_HW_BIT = 6;
	localparam int MODE_TIME_LSB = 3;
	localparam int MODE_EDGE_LSB = 1;
	localparam int MODE_BOOST_BIT = 0;

	// ****************************************
	// conversion time codes and counts
	// ****************************************
	localparam logic [2:0] TIME_144 = 3'h0;
	localparam logic [2:0] TIME_576 = 3'h4;
	localparam logic [2:0] TIME_480 = 3'h5;
	localparam logic [2:0] TIME_384 = 3'h6;
	localparam int CONV_CYC_144 = 144;
	localparam int CONV_CYC_576 = 576;
	localparam int CONV_CYC_480 = 480;
	localparam int CONV_CYC_384 = 384;
	// two sample steps then ten compare steps
	localparam int SEQ_STEPS = 12;
	localparam int SAMPLE_STEPS = 2;
	localparam int RES_BITS = 10;
	localparam int RES_PAD = 6;
	localparam int EXT_PINS = 6;
endpackage : adsc_pkg

// ===== verilog/adsc_sar_seq.sv
`timescale 1ns/1ns
module adsc_sar_seq (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// control side
	adsc_seq_if.seq sq
);
	typedef enum logic {SQ_IDLE, SQ_RUN} adsc_seq_e;

	adsc_seq_e state_reg, state_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [3:0] step_reg, step_next;
	logic [9:0] sar_reg, sar_next;
	logic [9:0] res_reg, res_next;
	logic done_reg, done_next;
	logic [3:0] bit_idx;
	logic [9:0] bit_mask;
	logic step_end;

	assign bit_idx = 4'(adsc_pkg::SEQ_STEPS - 1) - step_reg;
	assign bit_mask = 10'h001 << bit_idx;
	assign step_end = (cnt_reg == sq.step_len - 6'h01);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		step_next = step_reg;
		sar_next = sar_reg;
		res_next = res_reg;
		done_next = 1'b0;
		if (sq.abort) begin
			state_next = SQ_IDLE;
		end else if (state_reg == SQ_IDLE) begin
			if (sq.start) begin
				state_next = SQ_RUN;
				cnt_next = 6'h00;
				step_next = 4'h0;
				sar_next = 10'h000;
			end
		end else if (!step_end) begin
			cnt_next = cnt_reg + 6'h01; // R22
		end else begin
			cnt_next = 6'h00;
			step_next = step_reg + 4'h1;
			if (step_reg >= 4'(adsc_pkg::SAMPLE_STEPS)) begin
				// bit kept when input at or above the trial tap
				sar_next = sq.cmp ? (sar_reg | bit_mask) : sar_reg; // R14 R15 R22
			end
			if (step_reg == 4'(adsc_pkg::SEQ_STEPS - 1)) begin
				state_next = SQ_IDLE;
				res_next = sq.cmp ? (sar_reg | bit_mask) : sar_reg; // R16
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= SQ_IDLE;
			cnt_reg <= 6'h00;
			step_reg <= 4'h0;
			sar_reg <= 10'h000;
			res_reg <= 10'h000;
			done_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			step_reg <= step_next;
			sar_reg <= sar_next;
			res_reg <= res_next;
			done_reg <= done_next;
		end
	end

	assign sq.busy = (state_reg == SQ_RUN);
	assign sq.sampling = sq.busy && (step_reg < 4'(adsc_pkg::SAMPLE_STEPS)); // R13
	assign sq.trial = sq.busy && !sq.sampling ? (sar_reg | bit_mask) : 10'h000;
	assign sq.done = done_reg;
	assign sq.result = res_reg;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	seq_msb_first_a: assert property (sq.busy && step_reg == 4'h2 |-> sq.trial == 10'h200) // R14
		else $error("first trial is not the half tap");
	seq_abort_a: assert property (sq.abort && ce_i |=> !sq.busy) // R20 R21
		else $error("abort did not stop the sequencer");
endmodule : adsc_sar_seq

// ===== verilog/adsc_seq_if.sv
`timescale 1ns/1ns
interface adsc_seq_if;
	logic start;
	logic abort;
	logic [5:0] step_len;
	logic cmp;
	logic busy;
	logic sampling;
	logic [9:0] trial;
	logic done;
	logic [9:0] result;

	modport ctrl (output start, output abort, output step_len, output cmp,
		input busy, input sampling, input trial, input done, input result);
	modport seq (input start, input abort, input step_len, input cmp,
		output busy, output sampling, output trial, output done, output result);
endinterface : adsc_seq_if
